//--- hw/rsq_sequencer.sv
// rail sequencing timers, restart hold and temperature limit monitor
`timescale 1ns/1ns
module rsq_sequencer #(
  parameter int TICK_DIV = rsq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_nak,
  input wire logic [15:0] temp_reading,
  input wire logic temp_valid,
  input wire logic status_clear,
  output logic overtemp_fault,
  output logic undertemp_fault,
  output logic overtemp_warning,
  output logic temp_summary,
  output logic alert_n,
  input wire logic operation_on,
  input wire logic fault_shutdown,
  input wire logic run_i,
  output logic run_o,
  output logic run_oe,
  output logic run_enable,
  input wire logic output_above_low,
  input wire logic output_above_decay,
  input wire logic decay_monitor_enable,
  input wire logic continuous_mode,
  input wire logic setpoint_change,
  input wire logic setpoint_reached,
  output logic [2:0] seq_state,
  output logic ramp_active,
  output logic ramp_bypass,
  output logic force_discontinuous,
  output logic sink_enable,
  output logic outputs_hiz,
  output logic [TIMER_W-1:0] ramp_ticks,
  output logic [15:0] slew_rate,
  output logic slew_active,
  output logic powerup_timeout_flag,
  output logic decay_warning
);
  import rsq_pkg::*;

  // ----------------------------------------
  // command port and register file
  // ----------------------------------------
  logic [15:0] regs [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic signed [31:0] dec [NUM_REGS];
  logic [TIMER_W-1:0] dec_t [NUM_REGS];
  logic [15:0] rd_mux;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      localparam int FR = (gi == 0) ? FRAC_SLEW : ((gi <= 3) ? FRAC_TEMP : FRAC_TIME);
      assign hit[gi] = (cmd_code == CMD_CODE[gi]);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs[gi] <= REG_RESET[gi];
        end else if (ce && cmd_wr && hit[gi]) begin
          regs[gi] <= cmd_wdata;
        end
      end
      rsq_lin_decode #(.FRAC(FR)) u_dec (
        .word(regs[gi]),
        .value(dec[gi])
      );
      // negative times read as zero, large ones saturate
      assign dec_t[gi] = dec[gi][31] ? '0 :
                         ((dec[gi] > 32'sh00ff_ffff) ? {TIMER_W{1'b1}} : dec[gi][TIMER_W-1:0]);
    end
  endgenerate

  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (hit[i]) begin
        rd_mux = regs[i];
      end
    end
  end

  wire any_hit = |hit;
  wire cmd_req = cmd_wr || cmd_rd;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_rdata <= 16'h0000;
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
    end else if (ce) begin
      cmd_ack <= cmd_req && any_hit;
      cmd_nak <= cmd_req && !any_hit;
      if (cmd_rd && any_hit) begin
        cmd_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // decoded timing values with range limits
  // ----------------------------------------
  wire [TIMER_W-1:0] ton_wait_t = (dec_t[IDX_TON_WAIT] > WAIT_MAX_T) ? WAIT_MAX_T : dec_t[IDX_TON_WAIT];
  wire [TIMER_W-1:0] toff_wait_t = (dec_t[IDX_TOFF_WAIT] > WAIT_MAX_T) ? WAIT_MAX_T : dec_t[IDX_TOFF_WAIT];
  wire [TIMER_W-1:0] pu_t = (dec_t[IDX_PU_TIMEOUT] > WAIT_MAX_T) ? WAIT_MAX_T : dec_t[IDX_PU_TIMEOUT];
  wire [TIMER_W-1:0] rise_t = (dec_t[IDX_RISE] > RAMP_MAX_T) ? RAMP_MAX_T : dec_t[IDX_RISE];
  wire rise_bypass = (rise_t < RAMP_MIN_T);
  wire [TIMER_W-1:0] fall_t = (dec_t[IDX_FALL] < RAMP_MIN_T) ? RAMP_MIN_T :
                              ((dec_t[IDX_FALL] > RAMP_MAX_T) ? RAMP_MAX_T : dec_t[IDX_FALL]);
  wire [TIMER_W-1:0] decay_raw = dec_t[IDX_DECAY];
  wire decay_limit_off = (decay_raw == '0);
  wire [TIMER_W-1:0] decay_t = (decay_raw < DECAY_MIN_T) ? DECAY_MIN_T :
                               ((decay_raw > DECAY_MAX_T) ? DECAY_MAX_T : decay_raw);
  wire [TIMER_W-1:0] restart_t = dec_t[IDX_RESTART];
  wire [15:0] slew_raw = (dec[IDX_SLEW][31] || dec[IDX_SLEW] > 32'sh0000_ffff) ? 16'hffff : dec[IDX_SLEW][15:0];

  // ----------------------------------------
  // quarter ms timebase
  // ----------------------------------------
  logic [15:0] pre_cnt;
  wire tick = (pre_cnt == 16'(TICK_DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 16'h0000;
    end else if (ce) begin
      pre_cnt <= tick ? 16'h0000 : pre_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // run pin hold and restart delay
  // ----------------------------------------
  logic run_prev;
  logic holding;
  logic [TIMER_W-1:0] hold_cnt;
  wire run_fall = run_prev && !run_i && !holding;
  wire hold_done = holding && tick && (hold_cnt + 1'b1 >= restart_t);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_prev <= 1'b0;
      holding <= 1'b0;
      hold_cnt <= '0;
      run_enable <= 1'b0;
    end else if (ce) begin
      run_prev <= run_i;
      if (run_fall) begin
        holding <= (restart_t != '0);
        hold_cnt <= '0;
      end else if (hold_done) begin
        holding <= 1'b0;
      end else if (holding && tick) begin
        hold_cnt <= hold_cnt + 1'b1;
      end
      run_enable <= run_i && !holding && !run_fall;
    end
  end

  assign run_o = 1'b0;
  assign run_oe = holding;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  rsq_state_t state;
  rsq_state_t next_state;
  logic [TIMER_W-1:0] t_cnt;
  logic on_req_prev;
  wire on_req = run_enable && operation_on;
  wire start_ev = on_req && !on_req_prev;
  wire stop_ev = !on_req && on_req_prev;
  wire [TIMER_W-1:0] t_inc = t_cnt + 1'b1;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (start_ev) begin
          next_state = ST_ON_WAIT;
        end
      end
      ST_ON_WAIT: begin
        if (ton_wait_t == '0 || (tick && t_inc >= ton_wait_t)) begin
          next_state = rise_bypass ? ST_REGULATE : ST_RISE;
        end
      end
      ST_RISE: begin
        if (tick && t_inc >= rise_t) begin
          next_state = ST_REGULATE;
        end
      end
      ST_REGULATE: begin
        if (stop_ev) begin
          next_state = (toff_wait_t == '0) ? ST_FALL : ST_OFF_WAIT;
        end
      end
      ST_OFF_WAIT: begin
        if (tick && t_inc >= toff_wait_t) begin
          next_state = ST_FALL;
        end
      end
      ST_FALL: begin
        if (tick && t_inc >= fall_t) begin
          next_state = (decay_monitor_enable && !decay_limit_off) ? ST_DECAY : ST_OFF;
        end
      end
      ST_DECAY: begin
        if (!output_above_decay || (tick && t_inc >= decay_t)) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // fault shutdowns skip the turn-off wait
    if (fault_shutdown && state != ST_OFF && state != ST_FALL && state != ST_DECAY) begin
      next_state = ST_FALL;
    end else if (stop_ev && (state == ST_ON_WAIT || state == ST_RISE)) begin
      next_state = (toff_wait_t == '0) ? ST_FALL : ST_OFF_WAIT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_OFF;
      t_cnt <= '0;
      on_req_prev <= 1'b0;
    end else if (ce) begin
      on_req_prev <= on_req;
      state <= next_state;
      if (next_state != state) begin
        t_cnt <= '0;
      end else if (tick) begin
        t_cnt <= t_inc;
      end
    end
  end

  // ----------------------------------------
  // power-up timeout and decay warning
  // ----------------------------------------
  logic [TIMER_W-1:0] pu_cnt;
  logic pu_armed;
  wire pu_run = (state == ST_RISE || state == ST_REGULATE) && pu_armed;
  wire pu_expire = pu_run && (pu_t != '0) && tick && (pu_cnt + 1'b1 >= pu_t) && !output_above_low;
  wire decay_expire = (state == ST_DECAY) && output_above_decay && tick && (t_inc >= decay_t);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pu_cnt <= '0;
      pu_armed <= 1'b0;
      powerup_timeout_flag <= 1'b0;
      decay_warning <= 1'b0;
    end else if (ce) begin
      if (state == ST_ON_WAIT) begin
        pu_cnt <= '0;
        pu_armed <= 1'b1;
      end else if (pu_run && output_above_low) begin
        pu_armed <= 1'b0;
      end else if (pu_expire) begin
        pu_armed <= 1'b0;
      end else if (pu_run && tick) begin
        pu_cnt <= pu_cnt + 1'b1;
      end
      // set wins over clear
      powerup_timeout_flag <= pu_expire || (powerup_timeout_flag && !status_clear);
      decay_warning <= decay_expire || (decay_warning && !status_clear);
    end
  end

  // ----------------------------------------
  // slew handling for setpoint changes
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slew_active <= 1'b0;
    end else if (ce) begin
      if (state != ST_REGULATE || setpoint_reached) begin
        slew_active <= 1'b0;
      end else if (setpoint_change) begin
        slew_active <= 1'b1;
      end
    end
  end

  // host value is used as given up to the slope ceiling, negative values give the ceiling
  assign slew_rate = (slew_raw > SLOPE_MAX) ? SLOPE_MAX : slew_raw;

  // ----------------------------------------
  // ramp control outputs
  // ----------------------------------------
  assign seq_state = state;
  assign ramp_active = (state == ST_RISE) || (state == ST_FALL);
  assign ramp_bypass = rise_bypass;
  assign ramp_ticks = (state == ST_FALL) ? fall_t : rise_t;
  assign force_discontinuous = (state == ST_RISE);
  assign sink_enable = (state == ST_FALL) ? continuous_mode : (state == ST_REGULATE);
  assign outputs_hiz = (state == ST_OFF) || (state == ST_DECAY) || (state == ST_ON_WAIT);

  // ----------------------------------------
  // temperature limits
  // ----------------------------------------
  logic signed [31:0] temp_val;
  rsq_lin_decode #(.FRAC(FRAC_TEMP)) u_temp (
    .word(temp_reading),
    .value(temp_val)
  );

  wire ot_fault_ev = temp_valid && (temp_val > dec[IDX_OT_FAULT]);
  wire ot_warn_ev = temp_valid && (temp_val > dec[IDX_OT_WARN]);
  wire ut_fault_ev = temp_valid && (temp_val < dec[IDX_UT_FAULT]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overtemp_fault <= 1'b0;
      undertemp_fault <= 1'b0;
      overtemp_warning <= 1'b0;
      temp_summary <= 1'b0;
    end else if (ce) begin
      overtemp_fault <= ot_fault_ev || (overtemp_fault && !status_clear);
      undertemp_fault <= ut_fault_ev || (undertemp_fault && !status_clear);
      overtemp_warning <= ot_warn_ev || (overtemp_warning && !status_clear);
      temp_summary <= ot_fault_ev || ot_warn_ev || ut_fault_ev || (temp_summary && !status_clear);
    end
  end

  assign alert_n = !(overtemp_fault || undertemp_fault || overtemp_warning ||
                     powerup_timeout_flag || decay_warning);

endmodule : rsq_sequencer

//--- hw/rsq_pkg.sv
// shared constants for the rail sequencer and temperature limit block
package rsq_pkg;

  // ----------------------------------------
  // command codes and register indices
  // ----------------------------------------
  localparam int NUM_REGS = 11;
  localparam logic [3:0] IDX_SLEW = 4'h0;
  localparam logic [3:0] IDX_OT_FAULT = 4'h1;
  localparam logic [3:0] IDX_OT_WARN = 4'h2;
  localparam logic [3:0] IDX_UT_FAULT = 4'h3;
  localparam logic [3:0] IDX_TON_WAIT = 4'h4;
  localparam logic [3:0] IDX_RISE = 4'h5;
  localparam logic [3:0] IDX_PU_TIMEOUT = 4'h6;
  localparam logic [3:0] IDX_TOFF_WAIT = 4'h7;
  localparam logic [3:0] IDX_FALL = 4'h8;
  localparam logic [3:0] IDX_DECAY = 4'h9;
  localparam logic [3:0] IDX_RESTART = 4'ha;

  localparam logic [7:0] CMD_CODE [NUM_REGS] = '{
    8'h27, 8'h4f, 8'h51, 8'h53, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'hdc
  };
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'haa00, 16'heb20, 16'heaa8, 16'he580, 16'h8000, 16'hd200, 16'hd280, 16'h8000, 16'hd200, 16'hf258,
    16'hfbe8
  };

  // ----------------------------------------
  // linear word layout
  // ----------------------------------------
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;
  localparam int LIN_MANT_LSB = 0;
  localparam int LIN_SAT_SHIFT = 19;

  // fraction bits of each decoded value: quarter ms, quarter degree, 1/1024 V/ms
  localparam int FRAC_TIME = 2;
  localparam int FRAC_SLEW = 10;
  localparam int FRAC_TEMP = 2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 250000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 4;
  localparam int TIMER_W = 24;

  localparam int WAIT_MAX_MS = 83000;
  localparam int RAMP_MAX_MS = 1300;
  localparam int DECAY_MIN_MS = 120;
  localparam int DECAY_MAX_MS = 524000;
  localparam logic [TIMER_W-1:0] WAIT_MAX_T = TIMER_W'(WAIT_MAX_MS * TICKS_PER_MS);
  localparam logic [TIMER_W-1:0] RAMP_MAX_T = TIMER_W'(RAMP_MAX_MS * TICKS_PER_MS);
  localparam logic [TIMER_W-1:0] RAMP_MIN_T = TIMER_W'(1);
  localparam logic [TIMER_W-1:0] DECAY_MIN_T = TIMER_W'(DECAY_MIN_MS * TICKS_PER_MS);
  localparam logic [TIMER_W-1:0] DECAY_MAX_T = TIMER_W'(DECAY_MAX_MS * TICKS_PER_MS);

  // slope ceiling 4 V/ms in 1/1024 V/ms
  localparam int SLOPE_MAX_VPMS = 4;
  localparam logic [15:0] SLOPE_MAX = 16'(SLOPE_MAX_VPMS * 1024);

  typedef enum logic [2:0] {
    ST_OFF, ST_ON_WAIT, ST_RISE, ST_REGULATE, ST_OFF_WAIT, ST_FALL, ST_DECAY
  } rsq_state_t;

endpackage : rsq_pkg

//--- hw/rsq_lin_decode.sv
// linear 5s/11s word to scaled signed integer
`timescale 1ns/1ns
module rsq_lin_decode #(
  parameter int FRAC = 2
) (
  input wire logic [15:0] word,
  output logic signed [31:0] value
);
  import rsq_pkg::*;

  wire signed [4:0] exponent = word[LIN_EXP_MSB:LIN_EXP_LSB];
  wire signed [10:0] mantissa = word[LIN_MANT_MSB:LIN_MANT_LSB];
  wire signed [31:0] mant_ext = 32'(mantissa);
  wire signed [7:0] shift = 8'(exponent) + 8'(FRAC);
  wire signed [7:0] neg_shift = -shift;
  wire shift_left = !shift[7];
  wire saturate = shift_left && (shift >= 8'(LIN_SAT_SHIFT));
  wire signed [31:0] left_val = mant_ext <<< shift[4:0];
  wire signed [31:0] right_val = mant_ext >>> neg_shift[4:0];
  wire signed [31:0] sat_val = mantissa[10] ? -32'sh4000_0000 : 32'sh4000_0000;

  // exponent and mantissa both signed
  assign value = saturate ? sat_val : (shift_left ? left_val : right_val);

endmodule : rsq_lin_decode

//--- testbench/rsq_checker.sv
// port assertions for the rail sequencer
`timescale 1ns/1ns
module rsq_checker #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic cmd_ack,
  input wire logic cmd_nak,
  input wire logic temp_valid,
  input wire logic overtemp_fault,
  input wire logic undertemp_fault,
  input wire logic overtemp_warning,
  input wire logic temp_summary,
  input wire logic alert_n,
  input wire logic fault_shutdown,
  input wire logic run_i,
  input wire logic run_o,
  input wire logic run_oe,
  input wire logic run_enable,
  input wire logic continuous_mode,
  input wire logic [2:0] seq_state,
  input wire logic force_discontinuous,
  input wire logic sink_enable,
  input wire logic outputs_hiz,
  input wire logic [15:0] slew_rate,
  input wire logic powerup_timeout_flag,
  input wire logic decay_warning
);
  import rsq_pkg::*;
  // ----------------------------------------
  // request decode
  // ----------------------------------------
  wire logic req = ce && (cmd_wr || cmd_rd);
  wire logic known = cmd_code inside {8'h27, 8'h4f, 8'h51, 8'h53, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'hdc};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ack; req && known |=> cmd_ack && !cmd_nak; endproperty
  a_ack: assert property (p_ack) else $error("known code not acknowledged");
  property p_nak; req && !known |=> cmd_nak && !cmd_ack; endproperty
  a_nak: assert property (p_nak) else $error("unknown code not refused");
  property p_warn; $rose(overtemp_warning) |-> temp_summary && !alert_n && $past(temp_valid); endproperty
  a_warn: assert property (p_warn) else $error("warning without summary or alert");
  property p_otf; $rose(overtemp_fault) |-> $past(temp_valid) && !alert_n; endproperty
  a_otf: assert property (p_otf) else $error("overtemp fault without sample");
  property p_utf; $rose(undertemp_fault) |-> $past(temp_valid) && !alert_n; endproperty
  a_utf: assert property (p_utf) else $error("undertemp fault without sample");
  property p_alert;
    alert_n == !(overtemp_fault || undertemp_fault || overtemp_warning || powerup_timeout_flag || decay_warning);
  endproperty
  a_alert: assert property (p_alert) else $error("alert level wrong");
  property p_hold; $rose(run_oe) |-> !$past(run_i) && $past(run_i, 2) && !run_o; endproperty
  a_hold: assert property (p_hold) else $error("run hold without falling edge");
  property p_run_en; run_oe |=> !run_enable; endproperty
  a_run_en: assert property (p_run_en) else $error("run enable during hold");
  property p_fault; fault_shutdown && ce && seq_state == 3'(ST_REGULATE) |=> seq_state == 3'(ST_FALL); endproperty
  a_fault: assert property (p_fault) else $error("fault did not skip turn-off wait");
  property p_rise; seq_state == 3'(ST_RISE) |-> force_discontinuous; endproperty
  a_rise: assert property (p_rise) else $error("rise not discontinuous");
  property p_sink; seq_state == 3'(ST_FALL) && !continuous_mode |-> !sink_enable; endproperty
  a_sink: assert property (p_sink) else $error("sinking in discontinuous fall");
  property p_slew; slew_rate <= SLOPE_MAX; endproperty
  a_slew: assert property (p_slew) else $error("slew above ceiling");
  property p_hiz; seq_state == 3'(ST_OFF) |-> outputs_hiz; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs driven while off");

  c_nak: cover property (req && !known ##1 cmd_nak);
  c_hold: cover property ($rose(run_oe));
  c_decay: cover property ($rose(decay_warning));
endmodule : rsq_checker

bind rsq_sequencer rsq_checker #(.TICK_DIV(TICK_DIV)) i_chk (.clk, .rst, .ce, .cmd_code, .cmd_wr, .cmd_rd,
  .cmd_ack, .cmd_nak, .temp_valid, .overtemp_fault, .undertemp_fault, .overtemp_warning, .temp_summary, .alert_n,
  .fault_shutdown, .run_i, .run_o, .run_oe, .run_enable, .continuous_mode, .seq_state, .force_discontinuous,
  .sink_enable, .outputs_hiz, .slew_rate, .powerup_timeout_flag, .decay_warning);

//--- testbench/rsq_host_model.sv
// host model issuing word commands
`timescale 1ns/1ns
module rsq_host_model (
  input wire logic clk,
  output logic [7:0] cmd_code = 8'h00,
  output logic cmd_wr = 1'b0,
  output logic cmd_rd = 1'b0,
  output logic [15:0] cmd_wdata = 16'h0000,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_nak
);
  int idle = 0;
  // one whole 16-bit word per request
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d,
                      output logic [15:0] q, output logic ak, output logic nk);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    cmd_code <= c;
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    #1;
    q = cmd_rdata;
    ak = cmd_ack;
    nk = cmd_nak;
  endtask : xfer
endmodule : rsq_host_model

//--- testbench/testbench.sv
// self-checking bench for the rail sequencer
`timescale 1ns/1ns
module testbench;
  import rsq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, status_clear = 1'b0, temp_valid = 1'b0, run_drv = 1'b1;
  logic operation_on = 1'b0, fault_shutdown = 1'b0, output_above_low = 1'b0, output_above_decay = 1'b0;
  logic decay_monitor_enable = 1'b0, continuous_mode = 1'b0, setpoint_change = 1'b0, setpoint_reached = 1'b0;
  logic [15:0] temp_reading = 16'h0000, cmd_wdata, cmd_rdata, slew_rate;
  logic [7:0] cmd_code;
  logic cmd_wr, cmd_rd, cmd_ack, cmd_nak, overtemp_fault, undertemp_fault, overtemp_warning, temp_summary;
  logic alert_n, run_o, run_oe, run_enable, force_discontinuous, sink_enable, outputs_hiz, ramp_bypass;
  logic slew_active, powerup_timeout_flag, decay_warning, ramp_active;
  logic [2:0] seq_state;
  logic [TIMER_W-1:0] ramp_ticks;
  wire logic run_i = run_oe ? run_o : run_drv;
  int err_total = 0, n_checks = 0, n;
  always #20 clk = ~clk;

  rsq_host_model i_host (.clk, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nak);
  rsq_sequencer #(.TICK_DIV(4)) i_dut (.clk, .rst, .ce, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata,
    .cmd_ack, .cmd_nak, .temp_reading, .temp_valid, .status_clear, .overtemp_fault, .undertemp_fault,
    .overtemp_warning, .temp_summary, .alert_n, .operation_on, .fault_shutdown, .run_i, .run_o, .run_oe,
    .run_enable, .output_above_low, .output_above_decay, .decay_monitor_enable, .continuous_mode,
    .setpoint_change, .setpoint_reached, .seq_state, .ramp_active, .ramp_bypass, .force_discontinuous,
    .sink_enable, .outputs_hiz, .ramp_ticks, .slew_rate, .slew_active, .powerup_timeout_flag, .decay_warning);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chkw(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkw
  task automatic chkb(input logic got, input logic exp);
    chkw({23'h0, got}, {23'h0, exp});
  endtask : chkb
  task automatic acc(input logic [7:0] c, input logic w, input logic [15:0] d, input logic known);
    logic [15:0] q;
    logic ak, nk;
    i_host.xfer(c, w, d, q, ak, nk);
    chkb(ak, known);
    chkb(nk, !known);
    if (!w) chkw(24'(q), 24'(d));
  endtask : acc
  task automatic sense(input logic [15:0] w, input logic v, input logic c);
    @(posedge clk);
    temp_reading <= w;
    temp_valid <= v;
    status_clear <= c;
    @(posedge clk);
    temp_valid <= 1'b0;
    status_clear <= 1'b0;
    #1;
  endtask : sense
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_st(input logic [2:0] s);
    n = 0;
    while (seq_state !== s && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    chkw(24'(seq_state), 24'(s));
  endtask : wait_st
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) acc(CMD_CODE[i], 1'b0, REG_RESET[i], 1'b1);
    for (int i = 0; i < NUM_REGS; i++) begin
      acc(CMD_CODE[i], 1'b1, ~REG_RESET[i], 1'b1);
      acc(CMD_CODE[i], 1'b0, ~REG_RESET[i], 1'b1);
      acc(CMD_CODE[i], 1'b1, REG_RESET[i], 1'b1);
    end
    acc(8'h00, 1'b1, 16'h5555, 1'b0);
    i_host.idle = 3;
    acc(8'h51, 1'b0, 16'heaa8, 1'b1); // slow host, unknown code wrote nothing
    sense(16'heaa8, 1'b1, 1'b0);
    chkb(alert_n, 1'b1); // reading equal to limit
    sense(16'head0, 1'b1, 1'b0);
    chkb(overtemp_warning & temp_summary & !alert_n & !overtemp_fault, 1'b1);
    sense(16'heb70, 1'b1, 1'b0);
    chkb(overtemp_fault, 1'b1);
    sense(16'heb70, 1'b0, 1'b1);
    chkb(alert_n, 1'b1); // cleared
    sense(16'hee70, 1'b1, 1'b0);
    chkb(undertemp_fault & !overtemp_fault & !overtemp_warning, 1'b1);
    sense(16'hee70, 1'b0, 1'b1);
    acc(8'h60, 1'b1, 16'h0001, 1'b1);
    acc(8'h65, 1'b1, 16'h8000, 1'b1);
    @(posedge clk);
    operation_on <= 1'b1;
    wait_st(3'(ST_ON_WAIT));
    wait_st(3'(ST_RISE));
    chkb(n >= 12 && n <= 17, 1'b1);
    chkb(force_discontinuous & ramp_active & !ramp_bypass, 1'b1);
    chkw(ramp_ticks, 24'd32);
    wait_st(3'(ST_REGULATE));
    chkb(n >= 124 && n <= 133 && !powerup_timeout_flag, 1'b1);
    cyc(40);
    chkb(powerup_timeout_flag & !alert_n, 1'b1);
    @(posedge clk);
    output_above_low <= 1'b1;
    chkw(24'(slew_rate), 24'h000100);
    setpoint_change <= 1'b1;
    @(posedge clk);
    setpoint_change <= 1'b0;
    cyc(1);
    chkb(slew_active, 1'b1);
    acc(8'h27, 1'b1, 16'h0008, 1'b1);
    chkw(24'(slew_rate), 24'h001000);
    @(posedge clk);
    setpoint_reached <= 1'b1;
    cyc(2);
    chkb(slew_active, 1'b0);
    sense(16'h0000, 1'b0, 1'b1);
    chkb(alert_n & !powerup_timeout_flag, 1'b1); // cleared
    @(posedge clk);
    decay_monitor_enable <= 1'b1;
    output_above_decay <= 1'b1;
    operation_on <= 1'b0;
    wait_st(3'(ST_FALL));
    chkb(n <= 3, 1'b1);
    chkw(ramp_ticks, 24'd1);
    chkb(sink_enable, 1'b0);
    wait_st(3'(ST_DECAY));
    chkb(n <= 9, 1'b1);
    ce <= 1'b0;
    cyc(100); // frozen timers
    ce <= 1'b1;
    cyc(2380);
    chkb(decay_warning, 1'b0);
    cyc(40);
    chkb(decay_warning & !alert_n, 1'b1);
    @(posedge clk);
    output_above_decay <= 1'b0;
    wait_st(3'(ST_OFF));
    chkb(outputs_hiz, 1'b1);
    acc(8'h61, 1'b1, 16'h8000, 1'b1);
    chkb(ramp_bypass, 1'b1);
    acc(8'h64, 1'b1, 16'h0001, 1'b1);
    @(posedge clk);
    operation_on <= 1'b1;
    wait_st(3'(ST_REGULATE));
    chkb(n <= 22 && !outputs_hiz, 1'b1);
    @(posedge clk);
    fault_shutdown <= 1'b1;
    continuous_mode <= 1'b1;
    wait_st(3'(ST_FALL));
    chkb(n <= 2, 1'b1);
    chkb(sink_enable, 1'b1);
    @(posedge clk);
    fault_shutdown <= 1'b0;
    operation_on <= 1'b0;
    wait_st(3'(ST_OFF));
    acc(8'hdc, 1'b1, 16'h0008, 1'b1);
    @(posedge clk);
    run_drv <= 1'b0;
    cyc(2);
    chkb(run_oe & !run_o, 1'b1);
    @(posedge clk);
    run_drv <= 1'b1;
    for (n = 3; run_oe === 1'b1 && n < 500; n++) cyc(1);
    chkb(n >= 126 && n <= 134 && !run_enable, 1'b1);
    cyc(2);
    chkb(run_enable, 1'b1);
    report_and_stop();
  end
endmodule : testbench
